// ---- shared/vip_cfg.svh ----
// Purpose: constants of the vectored interrupt prioritizer
// Assumes: included by bare name from the design only, not from the package
// Notes: vectors are 16-bit table addresses
`ifndef VIP_CFG_SVH
`define VIP_CFG_SVH
`define VIP_NUM_MASKABLE 13
`define VIP_NUM_EXT 4
`define VIP_NUM_SOURCES 15
`define VIP_VEC_NMI 16'h0004
`define VIP_VEC_MASK_BASE 16'h0006
`define VIP_VEC_BRK 16'h003E
`define VIP_VEC_STEP 16'h0002
`define VIP_MASK_RST 13'h1FFF
`define VIP_PRIO_RST 13'h1FFF
`define VIP_REQ_RST 13'h0000
`define VIP_ADDR_REQ 3'h0
`define VIP_ADDR_MASK 3'h1
`define VIP_ADDR_PRIO 3'h2
`define VIP_ADDR_STAT 3'h3
`define VIP_ADDR_CTRL 3'h4
`define VIP_EDGE_FALL 2'h0
`define VIP_EDGE_RISE 2'h1
`define VIP_EDGE_BOTH 2'h3
`define VIP_CTRL_RST 8'h00
`endif

// ---- shared/vip_pkg.sv ----
// Purpose: types of the vectored interrupt prioritizer
// Assumes: nothing
// Notes: state is one packed struct
package vip_pkg;
	typedef enum logic [2:0] {
		VIP_IDLE = 3'b001,
		VIP_GRANT = 3'b010,
		VIP_WAIT = 3'b100
	} vip_state_t;

	typedef struct packed {
		vip_state_t st;
		logic [12:0] req;
		logic [12:0] mask;
		logic [12:0] prio;
		logic [7:0] ctrl;
		logic [3:0] pin_prev;
		logic [1:0] in_svc;
		logic [15:0] vec;
		logic vec_valid;
		logic [3:0] src;
		logic [15:0] rdata;
	} vip_regs_t;
endpackage

// ---- src/vip_core.sv ----
// Purpose: priority arbitration and vectoring of fifteen interrupt sources
// Assumes: core handshakes vec_valid_o/ack_i, signals returns with reti_i
// Notes: register offsets are word indices on a plain strobe port
//
// Functional notes
// RULE1: watchdog NMI ignores enable, beats everything
// RULE2: watchdog mode-one overflow vectors to 0004H
// RULE3: interval mode overflow is maskable source 0
// RULE4: maskable requests masked, grouped by priority flag
// RULE5: high group may nest over low service
// RULE6: same group resolved by index, 0 first
// RULE7: NMI and maskable requests release standby
// RULE8: four pin plus nine peripheral requests
// RULE9: break vectors to 003EH, ignores enable
// RULE10: pins edge detected, priorities 1-4
// RULE11: serial channels priorities 5,6
// RULE12: watch interval priority 7
// RULE13: 16-bit timer match priority 8
// RULE14: 8-bit timers priorities 9,10
// RULE15: adc done priority 11
// RULE16: key scan lowest, 001CH
// RULE17: fifteen sources in total
// RULE18: acceptance clears the request flag
// RULE19: reset sets mask and priority flags
// RULE20: per-source request, mask, priority flags
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ns
`include "vip_cfg.svh"
module vip_core
	import vip_pkg::*;
#(
	parameter int NUM_SRC = `VIP_NUM_MASKABLE
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic [2:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	input wire logic watchdog_overflow_irq_i,
	input wire logic wdt_mode1_i,
	input wire logic ext_pin_irq_a_i,
	input wire logic ext_pin_irq_b_i,
	input wire logic ext_pin_irq_c_i,
	input wire logic ext_pin_irq_d_i,
	input wire logic serial_ch_a_done_irq_i,
	input wire logic serial_ch_b_done_irq_i,
	input wire logic watch_interval_irq_i,
	input wire logic timer16_match_irq_i,
	input wire logic timer8_a_match_irq_i,
	input wire logic timer8_b_match_irq_i,
	input wire logic adc_done_irq_i,
	input wire logic key_scan_irq_i,
	input wire logic break_instruction_i,
	input wire logic int_enable_i,
	input wire logic ack_i,
	input wire logic reti_i,
	output logic [15:0] vec_o,
	output logic vec_valid_o,
	output logic [3:0] src_o,
	output logic standby_release_o
);
	// ----------------------------------------------------------------
	// request sources and edges
	// ----------------------------------------------------------------
	vip_regs_t r;
	vip_regs_t next_r;
	logic [3:0] pins;
	logic [3:0] pin_edge;
	logic [12:0] raw;
	logic [12:0] pend;
	logic [12:0] hi_pend;
	logic [12:0] lo_pend;
	logic nmi_ev;
	logic [3:0] hi_idx;
	logic [3:0] lo_idx;
	logic hi_any;
	logic lo_any;

	assign pins = {ext_pin_irq_d_i, ext_pin_irq_c_i, ext_pin_irq_b_i, ext_pin_irq_a_i};
	assign nmi_ev = watchdog_overflow_irq_i && wdt_mode1_i; // RULE2

	genvar gi;
	generate
		for (gi = 0; gi < `VIP_NUM_EXT; gi++) begin : g_edge
			logic [1:0] sel;
			// last pin fixed to falling edge
			assign sel = (gi == 3) ? `VIP_EDGE_FALL : r.ctrl[2*gi +: 2];
			always_comb begin
				case (sel)
					`VIP_EDGE_RISE: pin_edge[gi] = pins[gi] & ~r.pin_prev[gi];
					`VIP_EDGE_BOTH: pin_edge[gi] = pins[gi] ^ r.pin_prev[gi];
					default: pin_edge[gi] = ~pins[gi] & r.pin_prev[gi];
				endcase
			end
		end
	endgenerate

	// index equals default priority
	assign raw = {key_scan_irq_i, // RULE16
		adc_done_irq_i, // RULE15
		timer8_b_match_irq_i, timer8_a_match_irq_i, // RULE14
		timer16_match_irq_i, // RULE13
		watch_interval_irq_i, // RULE12
		serial_ch_b_done_irq_i, serial_ch_a_done_irq_i, // RULE11
		pin_edge, // RULE10
		watchdog_overflow_irq_i && !wdt_mode1_i}; // RULE3 RULE8

	// ----------------------------------------------------------------
	// arbitration
	// ----------------------------------------------------------------
	assign pend = r.req & ~r.mask; // RULE20 RULE4
	assign hi_pend = pend & ~r.prio;
	assign lo_pend = pend & r.prio;

	always_comb begin
		hi_idx = 4'h0;
		lo_idx = 4'h0;
		hi_any = 1'b0;
		lo_any = 1'b0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (hi_pend[i]) begin
				hi_idx = 4'(i); // RULE6
				hi_any = 1'b1;
			end
			if (lo_pend[i]) begin
				lo_idx = 4'(i); // RULE6
				lo_any = 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [3:0] idx;
		logic take;
		idx = 4'h0;
		take = 1'b0;
		next_r = r;
		next_r.pin_prev = pins;
		if (wr_i) begin
			case (addr_i)
				`VIP_ADDR_REQ: next_r.req = wdata_i[12:0];
				`VIP_ADDR_MASK: next_r.mask = wdata_i[12:0];
				`VIP_ADDR_PRIO: next_r.prio = wdata_i[12:0];
				`VIP_ADDR_CTRL: next_r.ctrl = wdata_i[7:0];
				default: ;
			endcase
		end
		if (reti_i) begin
			if (r.in_svc[0])
				next_r.in_svc[0] = 1'b0;
			else
				next_r.in_svc[1] = 1'b0;
		end
		case (r.st)
			VIP_IDLE: begin
				if (nmi_ev) begin
					next_r.vec = `VIP_VEC_NMI; // RULE1 RULE2
					next_r.src = 4'hD;
					next_r.vec_valid = 1'b1;
					next_r.st = VIP_GRANT;
				end else if (break_instruction_i) begin
					next_r.vec = `VIP_VEC_BRK; // RULE9
					next_r.src = 4'hE;
					next_r.vec_valid = 1'b1;
					next_r.st = VIP_GRANT;
				end else if (int_enable_i && hi_any && !r.in_svc[0]) begin
					idx = hi_idx; // RULE5
					take = 1'b1;
				end else if (int_enable_i && lo_any && r.in_svc == 2'b00) begin
					idx = lo_idx;
					take = 1'b1;
				end
				if (take) begin
					// slots run on from the nmi slot; source 0 shares the first pin slot
					if (idx == 4'h0)
						next_r.vec = `VIP_VEC_MASK_BASE;
					else
						next_r.vec = `VIP_VEC_NMI + {11'h000, idx, 1'b0}; // RULE10
					next_r.src = idx;
					next_r.vec_valid = 1'b1;
					next_r.st = VIP_GRANT;
					next_r.req[idx] = 1'b0; // RULE18
					if (!r.prio[idx])
						next_r.in_svc[0] = 1'b1;
					else
						next_r.in_svc[1] = 1'b1;
				end
			end
			VIP_GRANT: begin
				if (ack_i) begin
					next_r.vec_valid = 1'b0;
					next_r.st = VIP_WAIT;
				end
			end
			VIP_WAIT: next_r.st = VIP_IDLE;
			default: next_r.st = VIP_IDLE;
		endcase
		next_r.req = next_r.req | raw; // set beats clear
		if (rd_i) begin
			case (addr_i)
				`VIP_ADDR_REQ: next_r.rdata = {3'h0, r.req};
				`VIP_ADDR_MASK: next_r.rdata = {3'h0, r.mask};
				`VIP_ADDR_PRIO: next_r.rdata = {3'h0, r.prio};
				`VIP_ADDR_STAT: next_r.rdata = {9'h000, r.src, r.in_svc, r.vec_valid};
				`VIP_ADDR_CTRL: next_r.rdata = {8'h00, r.ctrl};
				default: next_r.rdata = 16'h0000;
			endcase
		end else begin
			next_r.rdata = 16'h0000;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			r <= '0;
			r.st <= VIP_IDLE;
			r.mask <= `VIP_MASK_RST; // RULE19
			r.prio <= `VIP_PRIO_RST; // RULE19
			r.ctrl <= `VIP_CTRL_RST;
			r.req <= `VIP_REQ_RST;
		end else begin
			r <= next_r;
		end
	end

	assign rdata_o = r.rdata;
	assign vec_o = r.vec;
	assign vec_valid_o = r.vec_valid;
	assign src_o = r.src;
	// masked sources do not wake the core
	assign standby_release_o = nmi_ev || (|pend); // RULE7 RULE17

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_nmi_grant;
		vec_valid_o && vec_o == `VIP_VEC_NMI;
	endsequence

	property p_nmi_first;
		@(posedge mclk_i) disable iff (rst_i)
		(r.st == VIP_IDLE && nmi_ev) |=> s_nmi_grant;
	endproperty
	a_nmi_first: assert property (p_nmi_first) else $error("nmi not granted"); // RULE1

	property p_nmi_vec;
		@(posedge mclk_i) disable iff (rst_i)
		(vec_valid_o && src_o == 4'hD) |-> vec_o == 16'h0004;
	endproperty
	a_nmi_vec: assert property (p_nmi_vec) else $error("bad nmi vector"); // RULE2

	property p_brk;
		@(posedge mclk_i) disable iff (rst_i)
		(r.st == VIP_IDLE && break_instruction_i && !nmi_ev) |=> vec_o == 16'h003E;
	endproperty
	a_brk: assert property (p_brk) else $error("bad break vector"); // RULE9

	property p_clear;
		@(posedge mclk_i) disable iff (rst_i)
		($rose(vec_valid_o) && src_o < 4'hD && ($past(raw) & (13'h0001 << src_o)) == 13'h0000)
			|-> !r.req[src_o];
	endproperty
	a_clear: assert property (p_clear) else $error("flag not cleared"); // RULE18

	property p_masked;
		@(posedge mclk_i) disable iff (rst_i)
		($rose(vec_valid_o) && src_o < 4'hD) |->
			($past(r.mask) & (13'h0001 << src_o)) == 13'h0000;
	endproperty
	a_masked: assert property (p_masked) else $error("masked source taken"); // RULE4

	property p_vec_map;
		@(posedge mclk_i) disable iff (rst_i)
		(vec_valid_o && src_o < 4'hD) |->
			vec_o == ((src_o == 4'h0) ? 16'h0006 : 16'h0004 + {11'h000, src_o, 1'b0});
	endproperty
	a_vec_map: assert property (p_vec_map) else $error("bad maskable vector"); // RULE10

	property p_order;
		@(posedge mclk_i) disable iff (rst_i)
		($rose(vec_valid_o) && src_o < 4'hD) |->
			($past(pend) & ((13'h0001 << src_o) - 13'h0001) & ~$past(r.prio)
				& ((($past(r.prio) & (13'h0001 << src_o)) != 13'h0000) ? 13'h0000 : 13'h1FFF))
				== 13'h0000;
	endproperty
	a_order: assert property (p_order) else $error("priority order broken"); // RULE6

	property p_wake;
		@(posedge mclk_i) disable iff (rst_i)
		((watchdog_overflow_irq_i && wdt_mode1_i) || (r.req & ~r.mask) != 13'h0000)
			|-> standby_release_o;
	endproperty
	a_wake: assert property (p_wake) else $error("no standby release"); // RULE7

	property p_nest;
		@(posedge mclk_i) disable iff (rst_i)
		($rose(vec_valid_o) && src_o < 4'hD && $past(r.in_svc[1])) |->
			($past(r.prio) & (13'h0001 << src_o)) == 13'h0000;
	endproperty
	a_nest: assert property (p_nest) else $error("low nested over low"); // RULE5

	property p_reset_flags;
		@(posedge mclk_i)
		rst_i |=> (r.mask == 13'h1FFF && r.prio == 13'h1FFF && r.req == 13'h0000);
	endproperty
	a_reset_flags: assert property (p_reset_flags) else $error("reset flags wrong"); // RULE19

	property p_wdt_mask;
		@(posedge mclk_i) disable iff (rst_i)
		(watchdog_overflow_irq_i && !wdt_mode1_i) |=> r.req[0];
	endproperty
	a_wdt_mask: assert property (p_wdt_mask) else $error("interval overflow lost"); // RULE3

	property p_enable;
		@(posedge mclk_i) disable iff (rst_i)
		($rose(vec_valid_o) && src_o < 4'hD) |-> $past(int_enable_i);
	endproperty
	a_enable: assert property (p_enable) else $error("maskable taken while disabled"); // RULE4

	property p_high_busy;
		@(posedge mclk_i) disable iff (rst_i)
		($rose(vec_valid_o) && src_o < 4'hD) |-> !$past(r.in_svc[0]);
	endproperty
	a_high_busy: assert property (p_high_busy) else $error("nested over high service"); // RULE5

	property p_low_order;
		@(posedge mclk_i) disable iff (rst_i)
		($rose(vec_valid_o) && src_o < 4'hD && ($past(r.prio) & (13'h0001 << src_o)) != 13'h0000)
			|-> ($past(lo_pend) & ((13'h0001 << src_o) - 13'h0001)) == 13'h0000
			&& $past(hi_pend) == 13'h0000;
	endproperty
	a_low_order: assert property (p_low_order) else $error("low group order broken"); // RULE6

	property p_pin_d_fall;
		@(posedge mclk_i) disable iff (rst_i)
		(!ext_pin_irq_d_i && r.pin_prev[3]) |=> r.req[4];
	endproperty
	a_pin_d_fall: assert property (p_pin_d_fall) else $error("pin d edge lost"); // RULE10

	property p_pin_a_rise;
		@(posedge mclk_i) disable iff (rst_i)
		(r.ctrl[1:0] == `VIP_EDGE_RISE && ext_pin_irq_a_i && !r.pin_prev[0]) |=> r.req[1];
	endproperty
	a_pin_a_rise: assert property (p_pin_a_rise) else $error("pin a rise lost"); // RULE10

	property p_brk_off;
		@(posedge mclk_i) disable iff (rst_i)
		(r.st == VIP_IDLE && break_instruction_i && !nmi_ev && !int_enable_i)
			|=> vec_valid_o && src_o == 4'hE;
	endproperty
	a_brk_off: assert property (p_brk_off) else $error("break lost while disabled"); // RULE9

	// a grant must not move under the core before it is taken
	sequence s_grant_up;
		vec_valid_o && $stable(vec_o) && $stable(src_o);
	endsequence

	property p_hold;
		@(posedge mclk_i) disable iff (rst_i)
		(vec_valid_o && !ack_i) |=> s_grant_up;
	endproperty
	a_hold: assert property (p_hold) else $error("grant changed before ack"); // RULE17
endmodule

// ---- testbench/vip_core_model.sv ----
// Purpose: core side that takes vectors from the prioritizer
// Assumes: one acknowledge per grant
// Notes: delay input gives a prompt or a slow core
`timescale 1ns/1ns
module vip_core_model (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic vec_valid_i,
	input wire logic [2:0] ack_dly_i,
	output logic ack_o
);
	// ----
	// acknowledge
	// ----
	logic [2:0] wait_cnt;
	// one-cycle ack, so a held vec_valid never takes two acks
	always_ff @(posedge mclk_i) begin
		if (rst_i || !vec_valid_i || ack_o) begin
			wait_cnt <= 3'h0;
			ack_o <= 1'h0;
		end else if (wait_cnt >= ack_dly_i) begin
			ack_o <= 1'h1;
		end else begin
			wait_cnt <= wait_cnt + 3'h1;
		end
	end
endmodule

// ---- testbench/tb_vectored_interrupt_prioritizer.sv ----
// Purpose: self-checking bench of the prioritizer
// Assumes: core model acknowledges every grant
// Notes: grants are sampled on falling edges
`timescale 1ns/1ns
module tb_vectored_interrupt_prioritizer;
	// ----
	// signals
	// ----
	logic mclk_i = 1'h0, rst_i = 1'h1, wr_i = 1'h0, rd_i = 1'h0, mode1 = 1'h0;
	logic break_instruction = 1'h0, en = 1'h0, reti = 1'h0, vld, ack, stby;
	logic [2:0] addr = 3'h0, dly = 3'h0;
	logic [15:0] wdata = 16'h0000, rdata, vec;
	logic [12:0] ev = 13'h0000;
	logic [3:0] pins = 4'hF, src;
	int errors = 0, samples_checked = 0;
	initial forever #25 mclk_i = ~mclk_i;
	vip_core DUT (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata), .watchdog_overflow_irq_i(ev[0]), .wdt_mode1_i(mode1),
		.ext_pin_irq_a_i(pins[0]), .ext_pin_irq_b_i(pins[1]), .ext_pin_irq_c_i(pins[2]),
		.ext_pin_irq_d_i(pins[3]), .serial_ch_a_done_irq_i(ev[5]),
		.serial_ch_b_done_irq_i(ev[6]), .watch_interval_irq_i(ev[7]),
		.timer16_match_irq_i(ev[8]), .timer8_a_match_irq_i(ev[9]),
		.timer8_b_match_irq_i(ev[10]), .adc_done_irq_i(ev[11]), .key_scan_irq_i(ev[12]),
		.break_instruction_i(break_instruction), .int_enable_i(en), .ack_i(ack), .reti_i(reti),
		.vec_o(vec), .vec_valid_o(vld), .src_o(src), .standby_release_o(stby));
	vip_core_model MODEL (.mclk_i(mclk_i), .rst_i(rst_i), .vec_valid_i(vld), .ack_dly_i(dly),
		.ack_o(ack));
	// ----
	// tasks
	// ----
	function automatic logic [15:0] mvec(input int k);
		// source 0 shares the first pin slot
		return (k == 0) ? 16'h0006 : 16'h0004 + 16'(2 * k);
	endfunction
	task print_verdict;
		$display("checks %0d, mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task reg_wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge mclk_i) begin
			addr <= a;
			wdata <= d;
			wr_i <= 1'h1;
		end
		@(posedge mclk_i) wr_i <= 1'h0;
	endtask
	task reg_rd(input logic [2:0] a, input logic [15:0] exp);
		@(posedge mclk_i) begin
			addr <= a;
			rd_i <= 1'h1;
		end
		@(posedge mclk_i) rd_i <= 1'h0;
		@(negedge mclk_i) check(rdata, exp);
	endtask
	task fire(input logic [12:0] e, input logic [3:0] p);
		@(posedge mclk_i) begin
			ev <= e;
			pins <= p;
		end
		@(posedge mclk_i) ev <= 13'h0000;
	endtask
	task ret;
		@(posedge mclk_i) reti <= 1'h1;
		@(posedge mclk_i) reti <= 1'h0;
	endtask
	task quiet;
		repeat (10) @(negedge mclk_i) check(vld, 1'h0);
	endtask
	// bounded wait for a grant, then for its release after the ack
	task grant(input logic [3:0] s, input logic [15:0] v);
		int n;
		n = 0;
		while (vld !== 1'h1 && n < 40) begin
			@(negedge mclk_i);
			n++;
		end
		if (n >= 40) begin
			errors++;
			print_verdict;
		end
		check(src, s);
		check(vec, v);
		while (vld === 1'h1 && n < 80) begin
			@(negedge mclk_i);
			n++;
		end
		if (vld === 1'h1) begin
			errors++;
			print_verdict;
		end
	endtask
	// ----
	// sequence
	// ----
	initial begin
		repeat (2) @(posedge mclk_i);
		rst_i <= 1'h0;
		reg_rd(3'h1, 16'h1FFF);
		reg_rd(3'h2, 16'h1FFF);
		reg_rd(3'h0, 16'h0000);
		$display("test reset done");
		reg_wr(3'h1, 16'h0000);
		en <= 1'h1;
		dly <= 3'h3;
		fire(13'h1FE1, 4'h0);
		for (int k = 0; k < 13; k++) begin
			grant(4'(k), mvec(k));
			ret;
		end
		$display("test default order done");
		dly <= 3'h0;
		reg_wr(3'h1, 16'h1FFF);
		fire(13'h0800, 4'h0);
		quiet;
		reg_rd(3'h0, 16'h0800);
		check(stby, 1'h0);
		@(posedge mclk_i) en <= 1'h0;
		reg_wr(3'h1, 16'h0000);
		@(negedge mclk_i) check(stby, 1'h1);
		@(posedge mclk_i) en <= 1'h1;
		grant(4'hB, 16'h001A);
		ret;
		reg_rd(3'h0, 16'h0000);
		$display("test mask done");
		reg_wr(3'h2, 16'h1FDF);
		fire(13'h1000, 4'h0);
		grant(4'hC, 16'h001C);
		fire(13'h0100, 4'h0);
		quiet;
		fire(13'h0020, 4'h0);
		grant(4'h5, 16'h000E);
		ret;
		quiet;
		ret;
		grant(4'h8, 16'h0014);
		ret;
		$display("test nesting done");
		reg_wr(3'h4, 16'h000D);
		reg_rd(3'h4, 16'h000D);
		fire(13'h0000, 4'h3);
		grant(4'h1, 16'h0006);
		ret;
		grant(4'h2, 16'h0008);
		ret;
		fire(13'h0000, 4'h0);
		grant(4'h2, 16'h0008);
		ret;
		quiet;
		reg_rd(3'h3, 16'h0010);
		$display("test edge select done");
		mode1 <= 1'h1;
		fire(13'h0801, 4'h0);
		grant(4'hD, 16'h0004);
		grant(4'hB, 16'h001A);
		ret;
		en <= 1'h0;
		fire(13'h0001, 4'h0);
		grant(4'hD, 16'h0004);
		@(posedge mclk_i) break_instruction <= 1'h1;
		@(posedge mclk_i) break_instruction <= 1'h0;
		grant(4'hE, 16'h003E);
		$display("test nmi and break done");
		print_verdict;
	end
endmodule
